// ===== verif/dspm_pad_model.sv
// board model of the seven pads: outside drivers, pulldowns and the shared pull-up
`timescale 1ns/10ps
module dspm_pad_model (
   // clock
   input  wire logic       i_clk,
   // pad controls from the block
   input  wire logic [6:0] i_pin_out,
   input  wire logic [6:0] i_pin_oe,
   input  wire logic [6:0] i_pin_pd_en,
   // outside drivers
   input  wire logic [6:0] i_ext_en,
   input  wire logic [6:0] i_ext_val,
   // resolved pad levels
   output logic      [6:0] o_level
);
   logic [6:0] level_q = 7'h00;

   always @(posedge i_clk) begin
      level_q <= o_level;
   end

   always_comb begin
      for (int n = 0; n < 7; n++) begin
         if (i_pin_oe[n]) begin
            o_level[n] = (n == dspm_pkg::OD_PIN) ? 1'b0 : i_pin_out[n];
         end else if (i_ext_en[n]) begin
            o_level[n] = i_ext_val[n];
         end else if (n == dspm_pkg::OD_PIN) begin
            o_level[n] = 1'b1;
         end else if (i_pin_pd_en[n]) begin
            o_level[n] = 1'b0;
         end else begin
            // undriven pad wanders so no stale level survives
            o_level[n] = ~level_q[n];
         end
      end
   end
endmodule : dspm_pad_model

// ===== verif/testbench.sv
// self-checking bench for the seven-pin block
`timescale 1ns/10ps
module testbench;
   logic        i_clk     = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic  [7:0] reg_addr  = 8'h00;
   logic  [7:0] reg_wdata = 8'h00;
   logic  [7:0] reg_rdata;
   logic  [6:0] pin_in, pin_out, pin_oe, pin_ie, pin_pd_en;
   logic  [6:0] ext_en    = 7'h76;
   logic  [6:0] ext_val   = 7'h52;
   logic        dev_irq   = 1'b0;
   logic  [7:0] rd_val;
   int          n_fail    = 0;
   int          cmp_count = 0;
   // fwd0, fwd1, lock, pass, fv, lv, port_en, sync, tx fv, tx lv, synced, tx irq
   localparam logic [22:0] SIG_A = {4'hA, 4'h5, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 5'b11010};
   localparam logic [22:0] SIG_B = {4'h5, 4'hA, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 5'b00101};
   logic [22:0] sig = SIG_A;
   // pin control byte, level under SIG_A, level under SIG_B
   localparam logic [9:0] ROWS [37] = '{
      {8'h03,2'b01}, {8'h05,2'b10}, {8'h09,2'b01}, {8'h0D,2'b10}, {8'h11,2'b10}, {8'h15,2'b01},
      {8'h19,2'b10}, {8'h1D,2'b01}, {8'h21,2'b10}, {8'h25,2'b01}, {8'h29,2'b10}, {8'h2D,2'b01},
      {8'h31,2'b01}, {8'h35,2'b10}, {8'h39,2'b01}, {8'h3D,2'b10}, {8'h43,2'b00}, {8'h63,2'b00},
      {8'h81,2'b00}, {8'h83,2'b11}, {8'h85,2'b10}, {8'h89,2'b00}, {8'h8D,2'b01}, {8'h91,2'b10},
      {8'h95,2'b00}, {8'h99,2'b11}, {8'h9F,2'b00}, {8'hA1,2'b01}, {8'hA5,2'b11}, {8'hA9,2'b10},
      {8'hAD,2'b01}, {8'hB1,2'b10}, {8'hB5,2'b01}, {8'hBB,2'b00}, {8'hBF,2'b00}, {8'hC3,2'b00},
      {8'hE3,2'b00}};

   always #2.5 i_clk = ~i_clk;

   dspm_pin_io_mux i_dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
      .o_pin_ie(pin_ie), .o_pin_pd_en(pin_pd_en),
      .i_rx0_fwd_pin(sig[22:19]), .i_rx1_fwd_pin(sig[18:15]), .i_rx_lock(sig[14:13]),
      .i_rx_pass(sig[12:11]), .i_rx_frame_valid(sig[10:9]), .i_rx_line_valid(sig[8:7]),
      .i_rx_port_en(sig[6:5]), .i_frame_sync(sig[4]), .i_dev_irq(dev_irq),
      .i_tx_frame_valid(sig[3]), .i_tx_line_valid(sig[2]), .i_rx_synced(sig[1]), .i_tx_irq(sig[0])
   );

   dspm_pad_model i_pads (
      .i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pin_pd_en(pin_pd_en),
      .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_in)
   );

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wait_cyc

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge i_clk);
      reg_wr = 1'b0;
      @(negedge i_clk);
      // pads settle one edge after the register
      @(negedge i_clk);
   endtask : write_reg

   task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge i_clk);
      reg_rd = 1'b0;
      rd_val = reg_rdata;
      check("register read", rd_val, e);
      @(negedge i_clk);
   endtask : check_reg

   task automatic do_reset();
      i_reset_n = 1'b0;
      wait_cyc(5);
      i_reset_n = 1'b1;
      wait_cyc(1);
      check("oe after reset", {1'b0, pin_oe}, 8'h00);
      check("ie after reset", {1'b0, pin_ie}, 8'h7F);
      check("pd after reset", {1'b0, pin_pd_en}, 8'h77);
   endtask : do_reset

   initial begin
      // roughly ten times the expected run
      #20000;
      n_fail++;
      stop_test();
   end

   initial begin
      @(negedge i_clk);
      do_reset();
      foreach (ROWS[r]) check_reg(dspm_pkg::ADDR_PIN0_CTL + 8'(r % 7), 8'h00);
      check_reg(dspm_pkg::ADDR_IN_CTL, 8'h00);
      check_reg(dspm_pkg::ADDR_PD_CTL, 8'h00);
      check_reg(dspm_pkg::ADDR_PIN_STS, 8'h5A);
      check_reg(8'h20, 8'h00);
      write_reg(dspm_pkg::ADDR_PIN_STS, 8'hFF);
      check_reg(dspm_pkg::ADDR_PIN_STS, 8'h5A);
      write_reg(dspm_pkg::ADDR_IN_CTL, 8'hFF);
      check_reg(dspm_pkg::ADDR_IN_CTL, 8'h77);
      check("ie all off", {1'b0, pin_ie}, 8'h08);
      write_reg(dspm_pkg::ADDR_IN_CTL, 8'h06);
      check("ie pins 1 2", {1'b0, pin_ie}, 8'h79);
      write_reg(dspm_pkg::ADDR_PD_CTL, 8'h07);
      check_reg(dspm_pkg::ADDR_PD_CTL, 8'h07);
      check("pd pins 0 to 2", {1'b0, pin_pd_en}, 8'h70);
      write_reg(dspm_pkg::ADDR_PD_CTL, 8'h00);
      write_reg(dspm_pkg::ADDR_IN_CTL, 8'h01);
      for (int p = 0; p < 2; p++) begin
         sig = (p == 0) ? SIG_A : SIG_B;
         foreach (ROWS[r]) begin
            write_reg(dspm_pkg::ADDR_PIN0_CTL, ROWS[r][9:2]);
            check("pin0 drive", {7'h00, pin_oe[0]}, 8'h01);
            check("pin0 level", {7'h00, pin_out[0]}, {7'h00, ROWS[r][1-p]});
         end
      end
      sig = SIG_A;
      write_reg(dspm_pkg::ADDR_PIN0_CTL, 8'h83);
      check_reg(dspm_pkg::ADDR_PIN_STS, 8'h5B);
      write_reg(dspm_pkg::ADDR_PIN0_CTL, 8'h02);
      check("pin0 released", {7'h00, pin_oe[0]}, 8'h00);
      write_reg(dspm_pkg::ADDR_PIN0_CTL + 8'h03, 8'h81);
      check("pin3 pulls low", {pin_oe[3], pin_out[3]}, 8'h02);
      check_reg(dspm_pkg::ADDR_PIN_STS, 8'h52);
      write_reg(dspm_pkg::ADDR_PIN0_CTL + 8'h03, 8'h83);
      check("pin3 released", {7'h00, pin_oe[3]}, 8'h00);
      dev_irq = 1'b1;
      wait_cyc(2);
      check("pin3 interrupt", {7'h00, pin_oe[3]}, 8'h01);
      dev_irq = 1'b0;
      write_reg(dspm_pkg::ADDR_PIN6_CTL, 8'hA4);
      check_reg(dspm_pkg::ADDR_PIN6_CTL, 8'hA4);
      do_reset();
      check_reg(dspm_pkg::ADDR_PIN6_CTL, 8'h00);
      stop_test();
   end
endmodule : testbench

// ===== verilog/dspm_out_mux.sv
// per-pin output function selector
`timescale 1ns/10ps
module dspm_out_mux (
   // pin control byte
   input  wire logic [7:0] i_ctl,
   // receive port signals
   input  wire logic [3:0] i_fwd0,
   input  wire logic [3:0] i_fwd1,
   input  wire logic [1:0] i_lock,
   input  wire logic [1:0] i_pass,
   input  wire logic [1:0] i_fv,
   input  wire logic [1:0] i_lv,
   input  wire logic [1:0] i_port_en,
   // device and transmit side signals
   input  wire logic       i_frame_sync,
   input  wire logic       i_dev_irq,
   input  wire logic       i_tx_fv,
   input  wire logic       i_tx_lv,
   input  wire logic       i_rx_synced,
   input  wire logic       i_tx_irq,
   // selected level
   output logic            o_level
);

   wire logic [2:0] src;
   wire logic [2:0] fsel;
   wire logic [7:0] grp_rx0;
   wire logic [7:0] grp_rx1;
   wire logic [7:0] grp_dev;
   wire logic [7:0] grp_tx;

   assign src  = i_ctl[dspm_pkg::SRC_MSB:dspm_pkg::SRC_LSB];
   assign fsel = i_ctl[dspm_pkg::FSEL_MSB:dspm_pkg::FSEL_LSB];

   assign grp_rx0 = {i_lv[0], i_fv[0], i_pass[0], i_lock[0], i_fwd0};
   assign grp_rx1 = {i_lv[1], i_fv[1], i_pass[1], i_lock[1], i_fwd1};
   // constant level used only here, ignored by every other source
   assign grp_dev = {1'b0, ~i_dev_irq, i_dev_irq, i_frame_sync,
                     dspm_pkg::all_enabled(i_pass, i_port_en),
                     dspm_pkg::all_enabled(i_lock, i_port_en),
                     |(i_lock & i_port_en),
                     i_ctl[dspm_pkg::OUT_VAL_BIT]};
   assign grp_tx  = {2'b00, i_tx_irq, i_rx_synced, i_tx_lv, i_tx_fv,
                     |(i_pass & i_port_en), dspm_pkg::all_enabled(i_pass, i_port_en)};

   // reserved sources drive low
   assign o_level = (src == dspm_pkg::SRC_RX0)     ? grp_rx0[fsel] :
                    (src == dspm_pkg::SRC_RX1)     ? grp_rx1[fsel] :
                    (src == dspm_pkg::SRC_DEV_STS) ? grp_dev[fsel] :
                    (src == dspm_pkg::SRC_TX_PORT) ? grp_tx[fsel]  : 1'b0;

endmodule : dspm_out_mux

// ===== verilog/dspm_pin_io_mux.sv
// seven-pin general purpose block with register port and output multiplexer
//
// Behaviour
// - seven pins controlled through contiguous registers
// - pin three is open-drain, shared with interrupt
// - status register returns every pin's level
// - after reset all pins are undriven inputs
// - input and pulldown disable for every pin except pin three, pulldown default on
// - input-control bit n disables pin n input, except pin three whose input stays on
// - separate pulldown-control register, one bit per pin except pin three, whose pulldown is enabled only in reset
// - receive port zero codes 0-3 forward remote pins
// - port zero codes 4-7 lock, pass, frame, line
// - source one is port one; source two reserved
// - device-status code zero drives constant level
// - device-status codes give lock, sync, interrupt signals
// - source five gives transmit-port group signals
`timescale 1ns/10ps
module dspm_pin_io_mux #(
   parameter int NUM_PINS = dspm_pkg::NUM_PINS
) (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_reset_n,
   // register port behind the serial control target
   input  wire logic                i_reg_wr,
   input  wire logic                i_reg_rd,
   input  wire logic [7:0]          i_reg_addr,
   input  wire logic [7:0]          i_reg_wdata,
   output logic      [7:0]          o_reg_rdata,
   // pads
   input  wire logic [NUM_PINS-1:0] i_pin_in,
   output logic      [NUM_PINS-1:0] o_pin_out,
   output logic      [NUM_PINS-1:0] o_pin_oe,
   output logic      [NUM_PINS-1:0] o_pin_ie,
   output logic      [NUM_PINS-1:0] o_pin_pd_en,
   // receive port signals
   input  wire logic [3:0]          i_rx0_fwd_pin,
   input  wire logic [3:0]          i_rx1_fwd_pin,
   input  wire logic [1:0]          i_rx_lock,
   input  wire logic [1:0]          i_rx_pass,
   input  wire logic [1:0]          i_rx_frame_valid,
   input  wire logic [1:0]          i_rx_line_valid,
   input  wire logic [1:0]          i_rx_port_en,
   // device and transmit side signals
   input  wire logic                i_frame_sync,
   input  wire logic                i_dev_irq,
   input  wire logic                i_tx_frame_valid,
   input  wire logic                i_tx_line_valid,
   input  wire logic                i_rx_synced,
   input  wire logic                i_tx_irq
);

   localparam int OD = dspm_pkg::OD_PIN;

   // control storage
   logic [7:0]          in_dis_q;
   logic [7:0]          pd_dis_q;
   logic [7:0]          ctl_q [NUM_PINS];
   logic [7:0]          rdata_q;
   logic [NUM_PINS-1:0] out_q;
   logic [NUM_PINS-1:0] oe_q;
   logic [NUM_PINS-1:0] ie_q;
   logic [NUM_PINS-1:0] pd_q;

   // address decode
   wire logic [7:0]          ctl_off;
   wire logic [2:0]          ctl_idx;
   wire logic                hit_sts;
   wire logic                hit_in;
   wire logic                hit_pd;
   wire logic                hit_ctl;
   wire logic [7:0]          rd_mux;
   wire logic [7:0]          ctl_rd;
   wire logic [NUM_PINS-1:0] level;
   wire logic [NUM_PINS-1:0] out_d;
   wire logic [NUM_PINS-1:0] oe_d;
   wire logic [NUM_PINS-1:0] ie_d;
   wire logic [NUM_PINS-1:0] pd_d;
   wire logic [7:0]          ctl_mask;

   assign ctl_off  = i_reg_addr - dspm_pkg::ADDR_PIN0_CTL;
   assign ctl_idx  = ctl_off[2:0];
   assign hit_sts  = (i_reg_addr == dspm_pkg::ADDR_PIN_STS);
   assign hit_in   = (i_reg_addr == dspm_pkg::ADDR_IN_CTL);
   assign hit_pd   = (i_reg_addr == dspm_pkg::ADDR_PD_CTL);
   assign hit_ctl  = (i_reg_addr >= dspm_pkg::ADDR_PIN0_CTL) &&
                     (i_reg_addr <= dspm_pkg::ADDR_PIN6_CTL);
   assign ctl_mask = {1'b0, dspm_pkg::CTL_PIN_MASK};
   assign ctl_rd   = hit_ctl ? ctl_q[ctl_idx] : 8'h00;

   // status reflects the pad, whatever its direction
   assign rd_mux = hit_sts ? {1'b0, i_pin_in}  :
                   hit_in  ? in_dis_q           :
                   hit_pd  ? pd_dis_q           :
                   ctl_rd;

   // register writes
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         in_dis_q <= dspm_pkg::RST_IN_CTL;
         pd_dis_q <= dspm_pkg::RST_PD_CTL;
      end else if (i_reg_wr) begin
         if (hit_in)
            in_dis_q <= i_reg_wdata & ctl_mask;
         if (hit_pd)
            pd_dis_q <= i_reg_wdata & ctl_mask;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int k = 0; k < NUM_PINS; k++)
            ctl_q[k] <= dspm_pkg::RST_PIN_CTL;
      end else if (i_reg_wr && hit_ctl) begin
         ctl_q[ctl_idx] <= i_reg_wdata;
      end
   end

   // read data holds until the next read
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         rdata_q <= 8'h00;
      else if (i_reg_rd)
         rdata_q <= rd_mux;
   end

   // per-pin function selection
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         dspm_out_mux u_mux (
            .i_ctl        (ctl_q[g]),
            .i_fwd0       (i_rx0_fwd_pin),
            .i_fwd1       (i_rx1_fwd_pin),
            .i_lock       (i_rx_lock),
            .i_pass       (i_rx_pass),
            .i_fv         (i_rx_frame_valid),
            .i_lv         (i_rx_line_valid),
            .i_port_en    (i_rx_port_en),
            .i_frame_sync (i_frame_sync),
            .i_dev_irq    (i_dev_irq),
            .i_tx_fv      (i_tx_frame_valid),
            .i_tx_lv      (i_tx_line_valid),
            .i_rx_synced  (i_rx_synced),
            .i_tx_irq     (i_tx_irq),
            .o_level      (level[g])
         );
         if (g == OD) begin : g_od
            // pulls low only; interrupt shares the pad
            assign out_d[g] = 1'b0;
            assign oe_d[g]  = i_dev_irq | (ctl_q[g][dspm_pkg::OUT_EN_BIT] & ~level[g]);
            assign ie_d[g]  = 1'b1;
            assign pd_d[g]  = 1'b0;
         end else begin : g_pp
            assign out_d[g] = level[g];
            assign oe_d[g]  = ctl_q[g][dspm_pkg::OUT_EN_BIT];
            assign ie_d[g]  = ~in_dis_q[g];
            assign pd_d[g]  = ~pd_dis_q[g];
         end
      end
   endgenerate

   // pad drivers registered
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_q <= '0;
         oe_q  <= '0;
         ie_q  <= '1;
         pd_q  <= '1;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
         ie_q  <= ie_d;
         pd_q  <= pd_d;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_pin_out   = out_q;
   assign o_pin_oe    = oe_q;
   assign o_pin_ie    = ie_q;
   assign o_pin_pd_en = pd_q;

   // checks
   wire logic [2:0] src0;
   wire logic [2:0] fsel0;
   assign src0  = ctl_q[0][dspm_pkg::SRC_MSB:dspm_pkg::SRC_LSB];
   assign fsel0 = ctl_q[0][dspm_pkg::FSEL_MSB:dspm_pkg::FSEL_LSB];

   sequence s_in_dis_write;
      i_reg_wr && hit_in && (i_reg_wdata[2:1] == 2'b11);
   endsequence

   sequence s_pd_dis_write;
      i_reg_wr && hit_pd && (i_reg_wdata[2:0] == 3'b111);
   endsequence

   sequence s_pin0_drives;
      ctl_q[0][dspm_pkg::OUT_EN_BIT] && !(i_reg_wr && hit_ctl);
   endsequence

   a_reset_inputs: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(!i_reset_n) |-> (o_pin_oe == '0) && (o_pin_ie == '1) && (o_pin_pd_en[2:0] == 3'h7))
      else $error("pins not idle inputs after reset");

   a_status_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_rd && hit_sts) |=> (o_reg_rdata == {1'b0, $past(i_pin_in)}))
      else $error("status read differs from pad level");

   a_input_disable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_in_dis_write |-> ##2 (o_pin_ie[2:1] == 2'b00))
      else $error("input paths not disabled after write");

   a_pulldown_ctl: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_pd_dis_write |-> ##2 (o_pin_pd_en[2:0] == 3'h0))
      else $error("pulldowns not disabled after write");

   a_open_drain: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_dev_irq |=> o_pin_oe[OD] && !o_pin_out[OD] && o_pin_ie[OD])
      else $error("shared pin not pulled low by interrupt");

   a_no_drive_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !ctl_q[0][dspm_pkg::OUT_EN_BIT] |=> !o_pin_oe[0])
      else $error("pin driven while drive bit clear");

   a_rx0_forward: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (s_pin0_drives and (src0 == dspm_pkg::SRC_RX0) and (fsel0 == 3'h2))
      |=> o_pin_oe[0] && (o_pin_out[0] == $past(i_rx0_fwd_pin[2])))
      else $error("remote pin value not forwarded");

   a_rx1_lock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_RX1) && (fsel0 == 3'h4)) |=> (o_pin_out[0] == $past(i_rx_lock[1])))
      else $error("port one lock not selected");

   a_const_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_DEV_STS) && (fsel0 == 3'h0))
      |=> (o_pin_out[0] == $past(ctl_q[0][dspm_pkg::OUT_VAL_BIT])))
      else $error("constant level not driven");

   a_lock_or: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_DEV_STS) && (fsel0 == 3'h1))
      |=> (o_pin_out[0] == $past(|(i_rx_lock & i_rx_port_en))))
      else $error("lock OR of enabled ports wrong");

   a_tx_group: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_TX_PORT) && (fsel0 == 3'h4)) |=> (o_pin_out[0] == $past(i_rx_synced)))
      else $error("port sync not selected");

   a_reserved_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == 3'h2) || (src0 >= 3'h6) || ((src0 == dspm_pkg::SRC_TX_PORT) && fsel0[2] && fsel0[1]))
      |=> !o_pin_out[0])
      else $error("reserved code did not drive low");

   a_pin_ie_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_pin_ie[1] == !$past(in_dis_q[1]))
      else $error("input enable does not follow control bit");

   a_pd_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_pin_pd_en[0] == !$past(pd_dis_q[0]))
      else $error("pulldown does not follow control bit");

   a_od_no_pull: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !$past(!i_reset_n) |-> !o_pin_pd_en[OD] && !o_pin_out[OD])
      else $error("shared pin has pulldown or drives high");

   a_od_released: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!i_dev_irq && !ctl_q[OD][dspm_pkg::OUT_EN_BIT]) |=> !o_pin_oe[OD])
      else $error("shared pin pulled low with no cause");

   a_od_input_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_pin_ie[OD])
      else $error("shared pin input path disabled");

   a_sts_read_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_wr && hit_sts) |=> $stable(in_dis_q) && $stable(pd_dis_q))
      else $error("status write changed control state");

   a_in_ctl_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_rd && hit_in) |=> (o_reg_rdata == $past(in_dis_q)))
      else $error("input control read differs");

   a_pd_ctl_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_rd && hit_pd) |=> (o_reg_rdata == $past(pd_dis_q)))
      else $error("pulldown control read differs");

   a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_rd && !hit_sts && !hit_in && !hit_pd && !hit_ctl) |=> (o_reg_rdata == 8'h00))
      else $error("unmapped read not zero");

   a_rsvd_bits_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((in_dis_q & ~ctl_mask) == 8'h00) && ((pd_dis_q & ~ctl_mask) == 8'h00))
      else $error("unused control bits set");

   a_ctl_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_wr && (i_reg_addr == dspm_pkg::ADDR_PIN6_CTL)) |=> (ctl_q[NUM_PINS-1] == $past(i_reg_wdata)))
      else $error("last pin control write lost");

   a_irq_low_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_DEV_STS) && (fsel0 == 3'h6)) |=> (o_pin_out[0] == !$past(i_dev_irq)))
      else $error("inverted interrupt not selected");

   a_tx_pass_or: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((src0 == dspm_pkg::SRC_TX_PORT) && (fsel0 == 3'h1))
      |=> (o_pin_out[0] == $past(|(i_rx_pass & i_rx_port_en))))
      else $error("pass OR of selected ports wrong");

endmodule : dspm_pin_io_mux

// ===== verilog/dspm_pkg.sv
// constants shared by the pin multiplexer block
package dspm_pkg;

   // register offsets
   localparam logic [7:0] ADDR_PIN_STS    = 8'h0E;
   localparam logic [7:0] ADDR_IN_CTL     = 8'h0F;
   localparam logic [7:0] ADDR_PIN0_CTL   = 8'h10;
   localparam logic [7:0] ADDR_PIN6_CTL   = 8'h16;
   localparam logic [7:0] ADDR_PD_CTL     = 8'hBE;

   // reset values
   localparam logic [7:0] RST_IN_CTL      = 8'h00;
   localparam logic [7:0] RST_PD_CTL      = 8'h00;
   localparam logic [7:0] RST_PIN_CTL     = 8'h00;

   // pin geometry
   localparam int         NUM_PINS        = 7;
   localparam int         OD_PIN          = 3;
   localparam logic [6:0] CTL_PIN_MASK    = 7'h77;

   // pin output control fields
   localparam int         SRC_MSB         = 7;
   localparam int         SRC_LSB         = 5;
   localparam int         FSEL_MSB        = 4;
   localparam int         FSEL_LSB        = 2;
   localparam int         OUT_VAL_BIT     = 1;
   localparam int         OUT_EN_BIT      = 0;

   // output source select codes
   localparam logic [2:0] SRC_RX0         = 3'h0;
   localparam logic [2:0] SRC_RX1         = 3'h1;
   localparam logic [2:0] SRC_DEV_STS     = 3'h4;
   localparam logic [2:0] SRC_TX_PORT     = 3'h5;

   // true when every enabled port shows the bit; false with no port enabled
   function automatic logic all_enabled(input logic [1:0] bits, input logic [1:0] en);
      all_enabled = (en != 2'h0) && ((bits & en) == en);
   endfunction : all_enabled

endpackage : dspm_pkg
